// ==== flc_loop_config.sv ====
// Purpose: Register file and control for the frequency locked loop setup.
// Assumes: Classic Wishbone slave, one wait state, byte address on wb_adr_i.
// Notes: Unmapped addresses ack with zero data and ignore writes.
//
// Our own choice: the Wishbone slave port.
`default_nettype none

module flc_loop_config
#(
    parameter int REF_LOSS_CYCLES = flc_pkg::REF_LOSS_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [flc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [flc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [flc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Reference pins: master, frame, bit clock
    input wire logic [flc_pkg::NUM_REF-1:0] ref_pins,
    // Loop controls toward the oscillator
    output logic loop_enable,
    output logic free_oscillator_enable,
    output logic fractional_mode_enable,
    output logic [flc_pkg::ODR_W-1:0] output_divide_ratio,
    output logic [flc_pkg::LRF_W-1:0] loop_ratio_factor,
    output logic [flc_pkg::N_W-1:0] multiplier_integer,
    output logic [flc_pkg::K_W-1:0] multiplier_fraction,
    output logic reference_tick,
    output logic loop_running
);
    import flc_pkg::*;

    localparam int LOSS_W = $clog2(REF_LOSS_CYCLES + 1);

    flc_ref_if refc ();

    // Register fields
    logic [OUTDIV_W-1:0] output_divider_select;
    logic [FRATIO_W-1:0] loop_ratio_select;
    logic [K_W-1:0] fraction_field;
    logic [N_W-1:0] integer_field;
    logic [PREDIV_W-1:0] reference_predivider;
    flc_src_t reference_source_select;
    logic changed_while_live;
    // Bus decode
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [REG_W-1:0] wdat;
    logic [REG_W-1:0] rdat;
    logic wr_loop;
    // Reference watch and state
    logic [LOSS_W-1:0] loss_cnt;
    logic ref_seen;
    flc_state_t state;
    flc_state_t next_state;

    // Request decode, low two byte lanes carry the 16-bit registers
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign idx = wb_adr_i[ADR_W-1:2];
    always_comb
    begin
        wdat = rdat;
        if (wb_sel_i[0])
        begin
            wdat[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
            wdat[15:8] = wb_dat_i[15:8];
        end
    end
    assign wr_loop = wr && (idx >= IDX_ENABLES) && (idx <= IDX_REFSEL);

    // Read mux, unused bits read as zero
    always_comb
    begin
        rdat = '0;
        unique case (idx)
            IDX_ENABLES:
            begin
                rdat[ENA_BIT] = loop_enable;
                rdat[OSC_BIT] = free_oscillator_enable;
                rdat[FRAC_BIT] = fractional_mode_enable;
            end
            IDX_DIVIDERS:
            begin
                rdat[OUTDIV_LSB +: OUTDIV_W] = output_divider_select;
                rdat[FRATIO_LSB +: FRATIO_W] = loop_ratio_select;
            end
            IDX_FRACTION: rdat[K_W-1:0] = fraction_field;
            IDX_INTEGER: rdat[N_LSB +: N_W] = integer_field;
            IDX_REFSEL:
            begin
                rdat[PREDIV_LSB +: PREDIV_W] = reference_predivider;
                rdat[SRC_LSB +: SRC_W] = reference_source_select;
            end
            IDX_STATUS:
            begin
                rdat[STAT_RUN] = loop_running;
                rdat[STAT_REF_SEEN] = ref_seen;
                rdat[STAT_BAD_SRC] = (reference_source_select == flc_src_reserved);
                rdat[STAT_CHG_LIVE] = changed_while_live;
            end
            default: rdat = '0;
        endcase
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? DAT_W'(rdat) : '0;
        end
    end

    // Enable bits
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            loop_enable <= 1'b0;
            free_oscillator_enable <= 1'b0;
            fractional_mode_enable <= 1'b0;
        end
        else if (wr && idx == IDX_ENABLES)
        begin
            loop_enable <= wdat[ENA_BIT];
            free_oscillator_enable <= wdat[OSC_BIT];
            fractional_mode_enable <= wdat[FRAC_BIT];
        end
    end

    // Divider fields
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            output_divider_select <= OUTDIV_RST;
            loop_ratio_select <= FRATIO_RST;
        end
        else if (wr && idx == IDX_DIVIDERS)
        begin
            output_divider_select <= wdat[OUTDIV_LSB +: OUTDIV_W];
            loop_ratio_select <= wdat[FRATIO_LSB +: FRATIO_W];
        end
    end

    // Multiplier fields
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fraction_field <= K_RST;
            integer_field <= N_RST;
        end
        else
        begin
            if (wr && idx == IDX_FRACTION)
            begin
                fraction_field <= wdat[K_W-1:0];
            end
            if (wr && idx == IDX_INTEGER)
            begin
                integer_field <= wdat[N_LSB +: N_W];
            end
        end
    end

    // Reference selection fields
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            reference_predivider <= PREDIV_RST;
            reference_source_select <= SRC_RST;
        end
        else if (wr && idx == IDX_REFSEL)
        begin
            reference_predivider <= wdat[PREDIV_LSB +: PREDIV_W];
            reference_source_select <= flc_src_t'(wdat[SRC_LSB +: SRC_W]);
        end
    end

    // Sticky flag: loop field written while loop_enable is set; write one clears
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            changed_while_live <= 1'b0;
        end
        else if (wr_loop && loop_enable && idx != IDX_ENABLES)
        begin
            changed_while_live <= 1'b1;
        end
        else if (wr && idx == IDX_STATUS && wdat[STAT_CHG_LIVE])
        begin
            changed_while_live <= 1'b0;
        end
    end

    // Selection toward the reference divider
    assign refc.src = reference_source_select;
    assign refc.prediv = reference_predivider;

    flc_ref_divider u_ref_div
    (
        .clk(clk),
        .srst(srst),
        .ref_pins(ref_pins),
        .refp(refc.gen)
    );

    // Reference presence watch on the divided reference
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            loss_cnt <= '0;
            ref_seen <= 1'b0;
        end
        else if (refc.tick)
        begin
            loss_cnt <= LOSS_W'(REF_LOSS_CYCLES);
            ref_seen <= 1'b1;
        end
        else if (loss_cnt != '0)
        begin
            loss_cnt <= loss_cnt - LOSS_W'(1);
        end
        else
        begin
            ref_seen <= 1'b0;
        end
    end

    // Run state: entered on a reference seen or the free oscillator, left only when loop_enable clears
    always_comb
    begin
        next_state = state;
        unique case (state)
            flc_idle:
                if (loop_enable)
                begin
                    next_state = flc_wait_ref;
                end
            flc_wait_ref:
                if (!loop_enable)
                begin
                    next_state = flc_idle;
                end
                else if (ref_seen || free_oscillator_enable)
                begin
                    next_state = flc_run;
                end
            flc_run:
                if (!loop_enable)
                begin
                    next_state = flc_idle;
                end
            default: next_state = flc_idle;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= flc_idle;
            loop_running <= 1'b0;
        end
        else
        begin
            state <= next_state;
            loop_running <= (next_state == flc_run);
        end
    end

    // Decoded settings toward the oscillator
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            output_divide_ratio <= ODR_BASE;
            loop_ratio_factor <= LRF_BASE;
            multiplier_integer <= N_RST;
            multiplier_fraction <= K_RST;
            reference_tick <= 1'b0;
        end
        else
        begin
            output_divide_ratio <= ODR_BASE << output_divider_select;
            loop_ratio_factor <= loop_ratio_select[FRATIO_W-1] ? LRF_MAX
                : (LRF_BASE << loop_ratio_select[FRATIO_W-2:0]);
            multiplier_integer <= integer_field;
            // Fraction only applies in fractional mode
            multiplier_fraction <= fractional_mode_enable ? fraction_field : K_RST;
            reference_tick <= refc.tick;
        end
    end
endmodule : flc_loop_config

`default_nettype wire

// ==== flc_loop_config_props.sv ====
// Purpose: Port-level checks for the loop clock configuration block.
// Assumes: Classic Wishbone slave answering one cycle after the taking edge.
// Notes: Field checks look two cycles after a taken write, enable bit checks one cycle after.
`default_nettype none

module flc_loop_config_props
#(
    parameter int REF_LOSS_CYCLES = flc_pkg::REF_LOSS_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [flc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [flc_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [flc_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Reference and loop controls
    input wire logic [flc_pkg::NUM_REF-1:0] ref_pins,
    input wire logic loop_enable,
    input wire logic free_oscillator_enable,
    input wire logic fractional_mode_enable,
    input wire logic [flc_pkg::ODR_W-1:0] output_divide_ratio,
    input wire logic [flc_pkg::LRF_W-1:0] loop_ratio_factor,
    input wire logic [flc_pkg::N_W-1:0] multiplier_integer,
    input wire logic [flc_pkg::K_W-1:0] multiplier_fraction,
    input wire logic reference_tick,
    input wire logic loop_running
);
    import flc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic wr;
    // Write taken at this edge
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    a_ack_single_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
    a_reset_defaults: assert property ($fell(srst) |-> !loop_enable &&
        !free_oscillator_enable && !fractional_mode_enable && output_divide_ratio == ODR_BASE
        && loop_ratio_factor == LRF_BASE && multiplier_integer == N_RST
        && multiplier_fraction == K_RST) else $error("defaults wrong after reset");
    a_enable_bits: assert property (wr && wb_adr_i == 10'h0f0 && wb_sel_i[0]
        |=> loop_enable == $past(wb_dat_i[0]) && free_oscillator_enable == $past(wb_dat_i[1])
        && fractional_mode_enable == $past(wb_dat_i[2])) else $error("enable bits wrong");
    a_outdiv_decode: assert property (wr && wb_adr_i == 10'h0f4 && wb_sel_i[1]
        |-> ##2 output_divide_ratio == (ODR_BASE << $past(wb_dat_i[10:8], 2)))
        else $error("output divide ratio wrong");
    a_ratio_decode: assert property (wr && wb_adr_i == 10'h0f4 && wb_sel_i[0]
        |-> ##2 loop_ratio_factor == ($past(wb_dat_i[2], 2) ? LRF_MAX
        : (LRF_BASE << $past(wb_dat_i[1:0], 2)))) else $error("loop ratio wrong");
    a_integer_field: assert property (wr && wb_adr_i == 10'h0fc && &wb_sel_i[1:0]
        |-> ##2 multiplier_integer == $past(wb_dat_i[14:5], 2)) else $error("integer wrong");
    a_fraction_gate: assert property (!fractional_mode_enable [*2]
        |-> multiplier_fraction == 16'h0000) else $error("fraction in integer mode");
    a_fraction_field: assert property (wr && wb_adr_i == 10'h0f8 && &wb_sel_i[1:0]
        && fractional_mode_enable |-> ##2 multiplier_fraction == $past(wb_dat_i[15:0], 2))
        else $error("fraction wrong");
    a_tick_single: assert property (reference_tick |=> !reference_tick)
        else $error("reference tick too long");
    a_run_needs_enable: assert property (!loop_enable [*3] |-> !loop_running)
        else $error("running while disabled");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    // Main scenarios reached
    c_enable_write: cover property (wr && wb_adr_i == 10'h0f0);
    c_tick: cover property (reference_tick);
    c_run: cover property ($rose(loop_running));
endmodule : flc_loop_config_props

bind flc_loop_config flc_loop_config_props #(.REF_LOSS_CYCLES(REF_LOSS_CYCLES)) i_props (
    .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ref_pins, .loop_enable, .free_oscillator_enable, .fractional_mode_enable,
    .output_divide_ratio, .loop_ratio_factor, .multiplier_integer, .multiplier_fraction,
    .reference_tick, .loop_running);

`default_nettype wire

// ==== flc_loop_config_tb.sv ====
// Purpose: Self-checking bench for the loop clock configuration block.
// Assumes: Reference pins toggle far slower than clk.
// Notes: Short reference loss window keeps the run brief.
`default_nettype none

module flc_loop_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flc_pkg::*;
    logic clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
    logic [NUM_REF-1:0] ref_pins;
    logic loop_enable, free_oscillator_enable, fractional_mode_enable;
    logic reference_tick, loop_running;
    logic [ODR_W-1:0] output_divide_ratio;
    logic [LRF_W-1:0] loop_ratio_factor;
    logic [N_W-1:0] multiplier_integer;
    logic [K_W-1:0] multiplier_fraction;
    logic [15:0] rd;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int ticks = 0;

    flc_loop_config #(.REF_LOSS_CYCLES(50)) i_flc_loop_config (.clk, .srst, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_pins,
        .loop_enable, .free_oscillator_enable, .fractional_mode_enable, .output_divide_ratio,
        .loop_ratio_factor, .multiplier_integer, .multiplier_fraction, .reference_tick,
        .loop_running);

    // Clock
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // Tick count and hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (reference_tick === 1'h1)
            ticks++;
        if (cycles == 10000)
        begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle, waits for ack, read data kept in rd
    task automatic wb_access(input logic [9:0] a, input logic w, input logic [15:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'h0000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o[15:0];
        check({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        @(posedge clk);
    endtask : wb_access

    task automatic rchk(input logic [9:0] a, input logic [15:0] m, input logic [15:0] exp);
        wb_access(a, 1'h0, 16'h0000, 4'h3);
        check({16'h0, rd & m}, {16'h0, exp});
    endtask : rchk

    task automatic reg_defaults();
        check({15'h0, loop_enable, free_oscillator_enable, fractional_mode_enable,
            output_divide_ratio, loop_ratio_factor}, {18'h0, 9'h002, 5'h01});
        check({6'h0, multiplier_integer, multiplier_fraction}, {6'h0, 10'h177, 16'h0});
        rchk(10'h0f0, 16'h0007, 16'h0000);
        rchk(10'h0f4, 16'h0707, 16'h0000);
        rchk(10'h0f8, 16'hffff, 16'h0000);
        rchk(10'h0fc, 16'h7fe0, 16'h2ee0);
        rchk(10'h100, 16'h001f, 16'h0002);
    endtask : reg_defaults

    // Selects a source, pulses one pin, counts divided ticks
    task automatic ref_run(input logic [4:0] sel, input int pin, input int edges,
        input int exp);
        wb_access(10'h100, 1'h1, {11'h0, sel}, 4'h1);
        ticks = 0;
        repeat (edges)
        begin
            ref_pins[pin] <= 1'h1;
            repeat (8) @(posedge clk);
            ref_pins[pin] <= 1'h0;
            repeat (8) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        check(32'(ticks), 32'(exp));
    endtask : ref_run

    // Main sequence
    initial
    begin
        srst = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = '0;
        ref_pins = '0;
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        reg_defaults();
        for (int i = 0; i < 8; i++)
        begin
            wb_access(10'h0f4, 1'h1, 16'(i * 16'h0101), 4'h3);
            check({23'h0, output_divide_ratio}, 32'h2 << i);
            check({27'h0, loop_ratio_factor}, (i > 3) ? 32'h10 : 32'h1 << i);
            rchk(10'h0f4, 16'h0707, 16'(i * 16'h0101));
        end
        wb_access(10'h0f8, 1'h1, 16'h3127, 4'h3);
        check({16'h0, multiplier_fraction}, 32'h0);
        wb_access(10'h0f8, 1'h1, 16'hffff, 4'h1);
        rchk(10'h0f8, 16'hffff, 16'h31ff);
        wb_access(10'h0f0, 1'h1, 16'h0004, 4'h3);
        check({16'h0, multiplier_fraction}, 32'h31ff);
        check(32'({fractional_mode_enable, free_oscillator_enable, loop_enable}), 32'h4);
        wb_access(10'h0fc, 1'h1, 16'h0100, 4'h3);
        check({22'h0, multiplier_integer}, 32'h8);
        wb_access(10'h0fc, 1'h1, 16'h7fe0, 4'h3);
        check({22'h0, multiplier_integer}, 32'h3ff);
        wb_access(10'h3fc, 1'h1, 16'hffff, 4'h3);
        rchk(10'h3fc, 16'hffff, 16'h0000);
        rchk(10'h0fc, 16'h7fe0, 16'h7fe0);
        for (int p = 0; p < 4; p++)
            ref_run(5'(p << 3), 0, 8, 8 >> p);
        ref_run(5'h01, 1, 4, 4);
        ref_run(5'h02, 2, 4, 4);
        ref_run(5'h03, 2, 4, 0);
        rchk(10'h120, 16'h0004, 16'h0004);
        ref_run(5'h02, 0, 4, 0);
        wb_access(10'h100, 1'h1, 16'h0000, 4'h1);
        wb_access(10'h0f0, 1'h1, 16'h0005, 4'h1);
        repeat (20) @(posedge clk);
        check({31'h0, loop_running}, 32'h0);
        ref_run(5'h00, 0, 2, 2);
        check({31'h0, loop_running}, 32'h1);
        // Running, reference seen, source legal, field written while live
        rchk(10'h120, 16'h000f, 16'h000b);
        wb_access(10'h120, 1'h1, 16'h0008, 4'h1);
        rchk(10'h120, 16'h0008, 16'h0000);
        wb_access(10'h0f0, 1'h1, 16'h0000, 4'h1);
        repeat (2) @(posedge clk);
        check({31'h0, loop_running}, 32'h0);
        wb_access(10'h0f0, 1'h1, 16'h0003, 4'h1);
        repeat (2) @(posedge clk);
        check({31'h0, loop_running}, 32'h1);
        check(32'({fractional_mode_enable, free_oscillator_enable, loop_enable}), 32'h3);
        // Worked setup: 12 MHz reference to 12.288 MHz, loop off while fields change
        wb_access(10'h0f0, 1'h1, 16'h0004, 4'h1);
        wb_access(10'h0f4, 1'h1, 16'h0200, 4'h3);
        wb_access(10'h100, 1'h1, 16'h0000, 4'h1);
        wb_access(10'h0fc, 1'h1, 16'h0100, 4'h3);
        wb_access(10'h0f8, 1'h1, 16'h3127, 4'h3);
        check({16'h0, multiplier_fraction}, 32'h3127);
        check({23'h0, output_divide_ratio}, 32'h8);
        check({22'h0, multiplier_integer}, 32'h8);
        wb_access(10'h0f0, 1'h1, 16'h0005, 4'h1);
        rchk(10'h120, 16'h0008, 16'h0000);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        reg_defaults();
        results();
    end
endmodule : flc_loop_config_tb

`default_nettype wire

// ==== flc_pkg.sv ====
// Purpose: Shared constants and types for the loop clock configuration block.
// Assumes: Wishbone word registers, byte address is four times the register index.
// Notes: Registers are 16 bits wide, carried in the low two lanes of the bus.
// Overview of operation
// - Loop reference is the selected input after the pre-divider, undivided when it divides by 1.
// - Bit 2 selects integer (0) or fractional (1) mode, reset 0.
// - Bit 0 enables loop, bit 1 enables free oscillator, both reset 0.
// - Output divider bits 10:8 divide by 2 up to 256, reset 000.
// - Loop ratio bits 2:0 give 1,2,4,8; top bit set gives 16.
// - Fraction is 16-bit unsigned, bits 15:0, MSB weight one half, reset 0.
// - Integer multiplier is 10 bits at 14:5, used in both modes.
// - Pre-divider bits 4:3 divide 1..8; source bits 1:0, reset bit clock.
`default_nettype none

package flc_pkg;
    // Bus widths
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;
    // Register indices; byte address is index times four
    localparam logic [7:0] IDX_ENABLES = 8'h3c;
    localparam logic [7:0] IDX_DIVIDERS = 8'h3d;
    localparam logic [7:0] IDX_FRACTION = 8'h3e;
    localparam logic [7:0] IDX_INTEGER = 8'h3f;
    localparam logic [7:0] IDX_REFSEL = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h48;
    // Field positions
    localparam int ENA_BIT = 0;
    localparam int OSC_BIT = 1;
    localparam int FRAC_BIT = 2;
    localparam int OUTDIV_LSB = 8;
    localparam int OUTDIV_W = 3;
    localparam int FRATIO_LSB = 0;
    localparam int FRATIO_W = 3;
    localparam int K_W = 16;
    localparam int N_LSB = 5;
    localparam int N_W = 10;
    localparam int PREDIV_LSB = 3;
    localparam int PREDIV_W = 2;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 2;
    // Status bits
    localparam int STAT_RUN = 0;
    localparam int STAT_REF_SEEN = 1;
    localparam int STAT_BAD_SRC = 2;
    localparam int STAT_CHG_LIVE = 3;
    // Reset values
    localparam logic [OUTDIV_W-1:0] OUTDIV_RST = 3'h0;
    localparam logic [FRATIO_W-1:0] FRATIO_RST = 3'h0;
    localparam logic [K_W-1:0] K_RST = 16'h0000;
    localparam logic [N_W-1:0] N_RST = 10'h177;
    localparam logic [PREDIV_W-1:0] PREDIV_RST = 2'h0;
    // Decoded widths
    localparam int ODR_W = 9;
    localparam int LRF_W = 5;
    localparam logic [ODR_W-1:0] ODR_BASE = 9'h002;
    localparam logic [LRF_W-1:0] LRF_BASE = 5'h01;
    localparam logic [LRF_W-1:0] LRF_MAX = 5'h10;
    // Reference loss timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int REF_LOSS_NS = 100000;
    localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int PIN_SYNC = 3;
    localparam int NUM_REF = 3;
    localparam int PDCNT_W = 3;

    // Reference source codes
    typedef enum logic [SRC_W-1:0] {
        flc_src_master = 2'h0,
        flc_src_frame = 2'h1,
        flc_src_bit = 2'h2,
        flc_src_reserved = 2'h3
    } flc_src_t;

    localparam flc_src_t SRC_RST = flc_src_bit;

    // Loop run states
    typedef enum logic [2:0] {
        flc_idle = 3'h1,
        flc_wait_ref = 3'h2,
        flc_run = 3'h4
    } flc_state_t;
endpackage : flc_pkg

`default_nettype wire

// ==== flc_ref_divider.sv ====
// Purpose: Synchronise the three reference pins, select one, pre-divide it.
// Assumes: Reference pins are far slower than clk.
// Notes: Reserved source gives no ticks at all.
`default_nettype none

module flc_ref_divider
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Reference pins: master, frame, bit clock
    input wire logic [flc_pkg::NUM_REF-1:0] ref_pins,
    // Selection and tick
    flc_ref_if.gen refp
);
    import flc_pkg::*;

    logic [NUM_REF-1:0] level;
    logic [NUM_REF-1:0] rise;
    logic [PDCNT_W-1:0] cnt;
    logic [PDCNT_W-1:0] terminal;
    logic sel_rise;
    flc_src_t src_q;
    logic [PREDIV_W-1:0] prediv_q;

    // Per pin three-stage synchroniser and rising edge
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REF; gi++)
        begin : g_pin
            logic [PIN_SYNC-1:0] sync;
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    sync <= '0;
                    level[gi] <= 1'b0;
                    rise[gi] <= 1'b0;
                end
                else
                begin
                    sync <= {sync[PIN_SYNC-2:0], ref_pins[gi]};
                    // Change counts once stages two and three agree
                    if (sync[1] == sync[2])
                    begin
                        level[gi] <= sync[2];
                    end
                    rise[gi] <= (sync[1] == sync[2]) && sync[2] && !level[gi];
                end
            end
        end
    endgenerate

    // Source select, reserved code picks nothing
    always_comb
    begin
        unique case (refp.src)
            flc_src_master: sel_rise = rise[0];
            flc_src_frame: sel_rise = rise[1];
            flc_src_bit: sel_rise = rise[2];
            default: sel_rise = 1'b0;
        endcase
    end

    // Division by 1, 2, 4 or 8 edges
    assign terminal = PDCNT_W'((1 << refp.prediv) - 1);

    // Pre-divider counter, restarts on any selection change
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt <= '0;
            refp.tick <= 1'b0;
            src_q <= SRC_RST;
            prediv_q <= PREDIV_RST;
        end
        else
        begin
            src_q <= refp.src;
            prediv_q <= refp.prediv;
            refp.tick <= 1'b0;
            if (src_q != refp.src || prediv_q != refp.prediv)
            begin
                cnt <= '0;
            end
            else if (sel_rise)
            begin
                if (cnt >= terminal)
                begin
                    cnt <= '0;
                    refp.tick <= 1'b1;
                end
                else
                begin
                    cnt <= cnt + PDCNT_W'(1);
                end
            end
        end
    end
endmodule : flc_ref_divider

`default_nettype wire

// ==== flc_ref_if.sv ====
// Purpose: Carries reference selection and divided tick between block modules.
// Assumes: One clock domain.
// Notes: Config side drives selection, generator side returns the tick.
`default_nettype none

interface flc_ref_if;
    import flc_pkg::*;
    flc_src_t src;
    logic [PREDIV_W-1:0] prediv;
    logic tick;

    modport cfg (output src, output prediv, input tick);
    modport gen (input src, input prediv, output tick);
endinterface : flc_ref_if

`default_nettype wire
